//--- hw/i2c_port.sv
// I2C port: slave stretching, general call, master byte engine and baud counter
// Function
// - 7-bit slave transmit stretches at ninth fall
// - Early buffer load prevents data-byte transmit stretching
// - Software may set release any time
// - 10-bit transmit: address stretch, third byte stretches at ninth fall
// - Hold SCL only after seen low
// - SCL low until release set and update flag clear
// - General call compared when enabled
// - General call loads buffer, flag at ninth
// - Address byte stays readable in buffer
// - 10-bit general call skips second byte
// - Master runs when enabled in master mode
// - Start/stop flags cleared; bus free decode
// - Write during busy master dropped, collision
// - Master flags every completed operation
// - Bytes of eight, each with acknowledge
// - Slave ack stored, flag after ninth
// - Stop request flags only when done
// - Baud reload from low 7 address bits
// - Baud count down twice per cycle, halt
// - Done operation halts clock, SCL kept
// - Master SCL low one rollover, high one
// - Baud held at reload value until SCL sampled high
`timescale 1ns/100ps
`include "i2c_port_params.svh"
module i2c_port #(
	parameter int BRG_W = 7
) (
	input  wire logic                  mclk_i,
	input  wire logic                  rst_i,
	input  wire logic                  link_clk_i,
	input  wire i2c_port_pkg::cfg_t    cfg_i,
	input  wire i2c_port_pkg::sw_req_t sw_req_i,
	input  wire logic [7:0]            buf_wdata_i,
	input  wire logic [7:0]            addr_wdata_i,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output logic                       scl_o,
	output logic                       scl_oe_o,
	output logic                       sda_o,
	output logic                       sda_oe_o,
	output logic [7:0]                 buf_rdata_o,
	output logic                       buffer_full_o,
	output logic                       scl_release_o,
	output logic                       addr_update_needed_o,
	output logic                       port_irq_flag_o,
	output logic                       write_collision_o,
	output logic                       ack_status_o,
	output logic                       begin_detected_o,
	output logic                       end_condition_flag_o,
	output logic                       bus_free_o,
	output logic                       rw_o
);
	// Counter width must hold the seven reload bits
	if (BRG_W != 7) begin : g_bad_w
		$error("BRG_W must be 7");
	end

	// Link domain: pin sampling and pin driving
	i2c_port_pkg::pin_pair_t pin_s1_r;    // First pin stage
	i2c_port_pkg::pin_pair_t pin_s2_r;    // Second pin stage
	i2c_port_pkg::pin_pair_t drv_c1_r;    // Drive request, first crossing stage
	i2c_port_pkg::pin_pair_t drv_c2_r;    // Drive request, second crossing stage
	logic [1:0]              lrst_r;      // Reset carried into link domain
	// Core domain
	i2c_port_pkg::pin_pair_t pin_c1_r;    // Sampled pins, first crossing stage
	i2c_port_pkg::pin_pair_t pin_c2_r;    // Sampled pins, usable
	i2c_port_pkg::pin_pair_t pin_c3_r;    // Previous usable sample, for edges
	i2c_port_pkg::pin_pair_t drv_r, drv_nxt; // Low-drive requests, 1 = pull low

	// Link domain: two stages on each pin before anything looks at it
	always_ff @(posedge link_clk_i) begin
		lrst_r   <= {lrst_r[0], rst_i};
		pin_s1_r <= {scl_i, sda_i};
		pin_s2_r <= pin_s1_r;
		drv_c1_r <= drv_r;
		drv_c2_r <= drv_c1_r;
		if (lrst_r[1]) begin
			scl_o    <= 1'b0;
			sda_o    <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			// Open drain: only ever drive low
			scl_o    <= 1'b0;
			sda_o    <= 1'b0;
			scl_oe_o <= drv_c2_r.scl;
			sda_oe_o <= drv_c2_r.sda;
		end
	end

	// Core domain: cross the sampled pin levels in
	always_ff @(posedge mclk_i) begin
		pin_c1_r <= pin_s2_r;
		pin_c2_r <= pin_c1_r;
		pin_c3_r <= pin_c2_r;
	end

	// Bus events seen from the settled samples
	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise  = pin_c2_r.scl & ~pin_c3_r.scl;
	assign scl_fall  = ~pin_c2_r.scl & pin_c3_r.scl;
	assign start_det = pin_c2_r.scl & pin_c3_r.scl & pin_c3_r.sda & ~pin_c2_r.sda;
	assign stop_det  = pin_c2_r.scl & pin_c3_r.scl & ~pin_c3_r.sda & pin_c2_r.sda;

	// Software visible state
	logic [7:0]       addr_r, addr_nxt;       // address_or_baud_reg
	logic [7:0]       buf_r, buf_nxt;         // shift_buffer
	logic             bf_r, bf_nxt;           // buffer_full
	logic             rel_r, rel_nxt;         // scl_release
	logic             ua_r, ua_nxt;           // addr_update_needed
	logic             irq_r, irq_nxt;         // port_irq_flag
	logic             write_collision_r, write_collision_nxt;       // write_collision
	logic             acks_r, acks_nxt;       // ack_status, bit 6 of control_reg2
	logic             beg_r, beg_nxt;         // begin_detected
	logic             end_r, end_nxt;         // end_condition_flag
	logic             rw_r, rw_nxt;           // Direction of last matched address
	logic             free_r, free_nxt;       // Bus free decode, held in a flop
	// Baud counter and phases
	logic [1:0]       ph_r, ph_nxt;           // Instruction cycle phase
	logic [BRG_W-1:0] brg_r, brg_nxt;         // baud_counter
	// Master engine
	i2c_port_pkg::mst_state_t ms_r, ms_nxt;
	logic [3:0]       mbit_r, mbit_nxt;       // Bit index 0..8
	logic [7:0]       msh_r, msh_nxt;         // Master shift register
	logic             mrx_r, mrx_nxt;         // Byte is a receive
	// Slave engine
	i2c_port_pkg::slv_state_t ss_r, ss_nxt;
	logic [3:0]       sbit_r, sbit_nxt;       // Bits completed in this byte
	logic [7:0]       ssh_r, ssh_nxt;         // shift_register, receive side
	logic [7:0]       stx_r, stx_nxt;         // Transmit shift register
	logic [1:0]       stg_r, stg_nxt;         // 10-bit address stage
	logic             m10_r, m10_nxt;         // 10-bit address fully matched
	logic             sack_r, sack_nxt;       // This byte is acknowledged
	logic             sard_r, sard_nxt;       // Byte just ended was a read address
	logic             hold_r, hold_nxt;       // Slave is pulling SCL low

	// Matching the upper seven bits is used in three places
	function automatic logic addr7_hit(input logic [7:0] sh, input logic [7:0] ad);
		addr7_hit = (sh[7:1] == ad[7:1]);
	endfunction

	logic tick, roll, m_on, s_on, m_busy_start;
	assign tick = (ph_r == `PH_TWO) || (ph_r == `PH_FOUR);
	assign roll = tick && (brg_r == '0);
	assign m_on = cfg_i.enable & cfg_i.master;
	assign s_on = cfg_i.enable & ~cfg_i.master;
	assign m_busy_start = (ms_r == i2c_port_pkg::M_ST_WAIT) ||
		(ms_r == i2c_port_pkg::M_ST_HOLD) || (ms_r == i2c_port_pkg::M_RS_LOW);

	// Next-state logic for the whole core
	always_comb begin
		logic set_irq;
		logic hit;
		logic gc;
		set_irq  = 1'b0;
		hit      = 1'b0;
		gc       = 1'b0;
		addr_nxt = addr_r;
		buf_nxt  = buf_r;
		bf_nxt   = bf_r;
		rel_nxt  = rel_r;
		ua_nxt   = ua_r;
		write_collision_nxt = write_collision_r;
		acks_nxt = acks_r;
		beg_nxt  = beg_r;
		end_nxt  = end_r;
		rw_nxt   = rw_r;
		ph_nxt   = ph_r + 2'h1;
		// Count down on both phases, then sit at zero until reloaded
		brg_nxt  = (tick && brg_r != '0) ? brg_r - 1'b1 : brg_r;
		ms_nxt   = ms_r;
		mbit_nxt = mbit_r;
		msh_nxt  = msh_r;
		mrx_nxt  = mrx_r;
		ss_nxt   = ss_r;
		sbit_nxt = sbit_r;
		ssh_nxt  = ssh_r;
		stx_nxt  = stx_r;
		stg_nxt  = stg_r;
		m10_nxt  = m10_r;
		sack_nxt = sack_r;
		sard_nxt = sard_r;
		drv_nxt  = drv_r;

		// Software strobes common to both modes
		if (sw_req_i.buf_rd) begin
			bf_nxt = 1'b0;
		end
		if (sw_req_i.addr_wr) begin
			addr_nxt = addr_wdata_i;
			ua_nxt   = 1'b0;                 // Updating the address lets SCL go
		end
		if (sw_req_i.write_collision_clr) begin
			write_collision_nxt = 1'b0;
		end

		// Bus condition flags follow the wires in either mode
		if (start_det) begin
			beg_nxt = 1'b1;
			end_nxt = 1'b0;
		end else if (stop_det) begin
			end_nxt = 1'b1;
			beg_nxt = 1'b0;
		end

		if (m_on) begin
			// Master byte engine
			if (sw_req_i.buf_wr) begin
				if (ms_r != i2c_port_pkg::M_IDLE) begin
					write_collision_nxt = 1'b1;         // No queueing: write dropped
				end else begin
					buf_nxt  = buf_wdata_i;
					bf_nxt   = 1'b1;
					msh_nxt  = buf_wdata_i;
					mrx_nxt  = 1'b0;
					mbit_nxt = '0;
					brg_nxt  = addr_r[6:0];  // Write starts the count
					ms_nxt   = i2c_port_pkg::M_BIT_LOW;
				end
			end
			case (ms_r)
				i2c_port_pkg::M_IDLE: begin
					// Requests only start from rest; start releases both lines, the others leave the clock where it was
					if (sw_req_i.start && !sw_req_i.buf_wr) begin
						drv_nxt = '0;
						// Fresh count so SDA falls only after a full high time
						brg_nxt = addr_r[6:0];
						ms_nxt  = i2c_port_pkg::M_ST_WAIT;
					end else if (sw_req_i.restart && !sw_req_i.buf_wr) begin
						brg_nxt = addr_r[6:0];
						ms_nxt  = i2c_port_pkg::M_RS_LOW;
					end else if (sw_req_i.stop && !sw_req_i.buf_wr) begin
						brg_nxt = addr_r[6:0];
						ms_nxt  = i2c_port_pkg::M_SP_LOW;
					end else if (sw_req_i.rx && !sw_req_i.buf_wr) begin
						mrx_nxt  = 1'b1;
						mbit_nxt = '0;
						brg_nxt  = addr_r[6:0];
						ms_nxt   = i2c_port_pkg::M_BIT_LOW;
					end
				end
				i2c_port_pkg::M_RS_LOW: begin
					// SCL low, SDA let go for one rollover
					drv_nxt.scl = 1'b1;
					drv_nxt.sda = 1'b0;
					if (roll) begin
						drv_nxt.scl = 1'b0;
						ms_nxt      = i2c_port_pkg::M_ST_WAIT;
					end
				end
				i2c_port_pkg::M_ST_WAIT: begin
					// Count only while both wires read high
					if (!(pin_c2_r.scl && pin_c2_r.sda)) begin
						brg_nxt = addr_r[6:0];
					end else if (roll) begin
						drv_nxt.sda = 1'b1;
						brg_nxt     = addr_r[6:0];
						ms_nxt      = i2c_port_pkg::M_ST_HOLD;
					end
				end
				i2c_port_pkg::M_ST_HOLD: begin
					if (roll) begin
						set_irq = 1'b1;          // Start done
						ms_nxt  = i2c_port_pkg::M_IDLE;
					end
				end
				i2c_port_pkg::M_BIT_LOW: begin
					// SCL low one rollover, data set up meanwhile
					drv_nxt.scl = 1'b1;
					if (mbit_r == `ACK_BIT) begin
						drv_nxt.sda = mrx_r & ~cfg_i.ack_data;
					end else begin
						drv_nxt.sda = ~mrx_r & ~msh_r[7];
					end
					if (roll) begin
						drv_nxt.scl = 1'b0;
						brg_nxt     = addr_r[6:0];
						ms_nxt      = i2c_port_pkg::M_BIT_HI;
					end
				end
				i2c_port_pkg::M_BIT_HI: begin
					// High time starts only once SCL really reads high
					if (!pin_c2_r.scl) begin
						brg_nxt = addr_r[6:0];
					end else if (roll) begin
						drv_nxt.scl = 1'b1;
						brg_nxt     = addr_r[6:0];
						ms_nxt      = i2c_port_pkg::M_BIT_LOW;
						mbit_nxt    = mbit_r + 4'h1;
						if (mbit_r != `ACK_BIT) begin
							msh_nxt = {msh_r[6:0], pin_c2_r.sda};
						end
						if (mbit_r == `LAST_BIT) begin
							if (mrx_r) begin
								buf_nxt = {msh_r[6:0], pin_c2_r.sda};
								bf_nxt  = 1'b1;
							end else begin
								bf_nxt  = 1'b0;  // All eight bits gone
							end
						end
						if (mbit_r == `ACK_BIT) begin
							if (!mrx_r) begin
								acks_nxt = pin_c2_r.sda;
							end
							set_irq = 1'b1;      // Byte plus ack done
							ms_nxt  = i2c_port_pkg::M_IDLE;  // Clock halts low
						end
					end
				end
				i2c_port_pkg::M_SP_LOW: begin
					drv_nxt.scl = 1'b1;
					drv_nxt.sda = 1'b1;
					if (roll) begin
						drv_nxt.scl = 1'b0;
						brg_nxt     = addr_r[6:0];
						ms_nxt      = i2c_port_pkg::M_SP_HI;
					end
				end
				i2c_port_pkg::M_SP_HI: begin
					if (!pin_c2_r.scl) begin
						brg_nxt = addr_r[6:0];
					end else if (roll) begin
						drv_nxt.sda = 1'b0;
						brg_nxt     = addr_r[6:0];
						ms_nxt      = i2c_port_pkg::M_SP_REL;
					end
				end
				i2c_port_pkg::M_SP_REL: begin
					if (roll) begin
						set_irq = 1'b1;          // Flag only after stop is out
						ms_nxt  = i2c_port_pkg::M_IDLE;
					end
				end
				default: begin
					ms_nxt  = i2c_port_pkg::M_IDLE;
					drv_nxt = '0;
				end
			endcase
		end else begin
			ms_nxt = i2c_port_pkg::M_IDLE;
		end

		if (s_on) begin
			// Software loads transmit data; release may be set at any time
			if (sw_req_i.buf_wr) begin
				buf_nxt = buf_wdata_i;
				stx_nxt = buf_wdata_i;
				bf_nxt  = 1'b1;
			end
			if (start_det) begin
				ss_nxt   = i2c_port_pkg::S_ADDR;
				sbit_nxt = '0;
				stg_nxt  = m10_r ? `STAGE_THIRD : `STAGE_HI;
				sack_nxt = 1'b0;
			end else if (stop_det) begin
				ss_nxt  = i2c_port_pkg::S_IDLE;
				m10_nxt = 1'b0;
			end else if (ss_r != i2c_port_pkg::S_IDLE) begin
				if (scl_rise) begin
					ssh_nxt = {ssh_r[6:0], pin_c2_r.sda};
					// Master not acknowledging ends a transmit
					if (ss_r == i2c_port_pkg::S_TX && sbit_r == `ACK_BIT &&
						!sard_r && pin_c2_r.sda) begin
						ss_nxt = i2c_port_pkg::S_IDLE;
					end
				end
				if (scl_fall) begin
					sbit_nxt = sbit_r + 4'h1;
					if (ss_r == i2c_port_pkg::S_TX && sbit_r < `ACK_BIT && !sard_r) begin
						stx_nxt = {stx_r[6:0], 1'b0};
					end
					if (sbit_r == `LAST_BIT) begin
						// Eighth falling edge: compare and load
						sard_nxt = 1'b0;
						if (ss_r == i2c_port_pkg::S_ADDR) begin
							gc = cfg_i.gce && (ssh_r == `GC_ADDR) &&
								(stg_r == `STAGE_HI);
							if (gc) begin
								hit    = 1'b1;
								ss_nxt = i2c_port_pkg::S_RX;  // No second byte
							end else if (!cfg_i.ten_bit) begin
								hit    = addr7_hit(ssh_r, addr_r);
								ss_nxt = ssh_r[0] ? i2c_port_pkg::S_TX
									: i2c_port_pkg::S_RX;
							end else if (stg_r == `STAGE_HI) begin
								hit     = addr7_hit(ssh_r, addr_r) && !ssh_r[0];
								ua_nxt  = hit;
								stg_nxt = `STAGE_LO;
							end else if (stg_r == `STAGE_LO) begin
								hit     = (ssh_r == addr_r);
								ua_nxt  = hit;
								m10_nxt = hit;
								ss_nxt  = i2c_port_pkg::S_RX;
							end else begin
								// Third byte: no update flag, go transmit
								hit    = addr7_hit(ssh_r, addr_r) && ssh_r[0];
								ss_nxt = i2c_port_pkg::S_TX;
							end
							if (!hit || bf_r) begin
								ss_nxt = i2c_port_pkg::S_IDLE;
								ua_nxt = ua_r;
								hit    = 1'b0;
							end else begin
								buf_nxt  = ssh_r;    // Address kept readable
								bf_nxt   = 1'b1;
								rw_nxt   = ssh_r[0];
								sard_nxt = ssh_r[0];
							end
							sack_nxt = hit;
						end else if (ss_r == i2c_port_pkg::S_RX) begin
							sack_nxt = ~bf_r;
							if (!bf_r) begin
								buf_nxt = ssh_r;
								bf_nxt  = 1'b1;
							end
						end else begin
							sack_nxt = 1'b0;
							bf_nxt   = 1'b0;         // Transmit byte fully shifted
						end
					end
					if (sbit_r == `ACK_BIT) begin
						// Ninth falling edge: flag and stretch decisions
						sbit_nxt = '0;
						if (sack_r || ss_r == i2c_port_pkg::S_TX) begin
							set_irq = 1'b1;
						end
						if (ss_r == i2c_port_pkg::S_TX && (sard_r || !bf_r)) begin
							rel_nxt = 1'b0;          // Stretch regardless of enable
						end
						if (ss_r == i2c_port_pkg::S_RX && cfg_i.stretch && bf_r) begin
							rel_nxt = 1'b0;
						end
						sack_nxt = 1'b0;
						sard_nxt = 1'b0;
					end
				end
			end
			// Slave SDA: ack in ninth bit, data bits in transmit
			if (sbit_nxt == `ACK_BIT) begin
				drv_nxt.sda = sack_nxt;
			end else if (ss_nxt == i2c_port_pkg::S_TX && !sard_nxt) begin
				drv_nxt.sda = ~stx_nxt[7];
			end else begin
				drv_nxt.sda = 1'b0;
			end
			// Pull SCL only after it already reads low, keep it until released
			hold_nxt    = (~rel_nxt | ua_nxt) & (hold_r | ~pin_c2_r.scl);
			drv_nxt.scl = hold_nxt;          // Wired-AND waits for all others
		end else begin
			ss_nxt   = i2c_port_pkg::S_IDLE;
			hold_nxt = 1'b0;
		end
		// Software release wins over a hardware stretch in the same cycle
		if (sw_req_i.rel_set) begin
			rel_nxt = 1'b1;
			if (s_on) begin
				hold_nxt    = ua_nxt & hold_nxt;
				drv_nxt.scl = hold_nxt;
			end
		end
		// Port disabled: forget bus conditions and stop driving
		if (!cfg_i.enable) begin
			beg_nxt = 1'b0;
			end_nxt = 1'b0;
			drv_nxt = '0;
			m10_nxt = 1'b0;
		end
		// Hardware set beats software clear
		irq_nxt = set_irq | (irq_r & ~sw_req_i.irq_clr);
		// Free when last condition was a stop, or nothing seen yet
		free_nxt = end_nxt | (~beg_nxt & ~end_nxt);
	end

	// Register every piece of core state
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			addr_r <= `ADDR_RST;
			buf_r  <= `BUF_RST;
			bf_r   <= 1'b0;
			rel_r  <= 1'b1;
			ua_r   <= 1'b0;
			irq_r  <= 1'b0;
			write_collision_r <= 1'b0;
			acks_r <= 1'b0;
			beg_r  <= 1'b0;
			end_r  <= 1'b0;
			rw_r   <= 1'b0;
			free_r <= 1'b1;
			ph_r   <= 2'h0;
			brg_r  <= `BRG_RST;
			ms_r   <= i2c_port_pkg::M_IDLE;
			mbit_r <= 4'h0;
			msh_r  <= 8'h00;
			mrx_r  <= 1'b0;
			ss_r   <= i2c_port_pkg::S_IDLE;
			sbit_r <= 4'h0;
			ssh_r  <= 8'h00;
			stx_r  <= 8'h00;
			stg_r  <= `STAGE_HI;
			m10_r  <= 1'b0;
			sack_r <= 1'b0;
			sard_r <= 1'b0;
			hold_r <= 1'b0;
			drv_r  <= '0;
		end else begin
			addr_r <= addr_nxt;
			buf_r  <= buf_nxt;
			bf_r   <= bf_nxt;
			rel_r  <= rel_nxt;
			ua_r   <= ua_nxt;
			irq_r  <= irq_nxt;
			write_collision_r <= write_collision_nxt;
			acks_r <= acks_nxt;
			beg_r  <= beg_nxt;
			end_r  <= end_nxt;
			rw_r   <= rw_nxt;
			free_r <= free_nxt;
			ph_r   <= ph_nxt;
			brg_r  <= brg_nxt;
			ms_r   <= ms_nxt;
			mbit_r <= mbit_nxt;
			msh_r  <= msh_nxt;
			mrx_r  <= mrx_nxt;
			ss_r   <= ss_nxt;
			sbit_r <= sbit_nxt;
			ssh_r  <= ssh_nxt;
			stx_r  <= stx_nxt;
			stg_r  <= stg_nxt;
			m10_r  <= m10_nxt;
			sack_r <= sack_nxt;
			sard_r <= sard_nxt;
			hold_r <= hold_nxt;
			drv_r  <= drv_nxt;
		end
	end

	// Status outputs straight from flops
	assign buf_rdata_o          = buf_r;
	assign buffer_full_o        = bf_r;
	assign scl_release_o        = rel_r;
	assign addr_update_needed_o = ua_r;
	assign port_irq_flag_o      = irq_r;
	assign write_collision_o    = write_collision_r;
	assign ack_status_o         = acks_r;
	assign begin_detected_o     = beg_r;
	assign end_condition_flag_o = end_r;
	assign rw_o                 = rw_r;
	assign bus_free_o           = free_r;
	// Master busy in a start is folded into the collision check above
	logic unused_busy;
	assign unused_busy = m_busy_start;
endmodule

//--- shared/i2c_port_params.svh
// Reset values, field positions and timing counts of the I2C port block
`ifndef I2C_PORT_PARAMS_SVH
`define I2C_PORT_PARAMS_SVH
`define ADDR_RST      8'h00
`define BUF_RST       8'h00
`define BRG_RST       7'h00
`define GC_ADDR       8'h00
`define TENBIT_HI     5'h1e
`define PH_TWO        2'h1
`define PH_FOUR       2'h3
`define LAST_BIT      4'h7
`define ACK_BIT       4'h8
`define STAGE_HI      2'h0
`define STAGE_LO      2'h1
`define STAGE_THIRD   2'h2
`endif

//--- shared/i2c_port_pkg.sv
// Types shared by the I2C port block and its bench
package i2c_port_pkg;
	// Sampled or driven pair of bus wires
	typedef struct packed {
		logic scl;
		logic sda;
	} pin_pair_t;
	// One-cycle software strobes
	typedef struct packed {
		logic buf_wr;
		logic buf_rd;
		logic addr_wr;
		logic rel_set;
		logic start;
		logic restart;
		logic stop;
		logic rx;
		logic irq_clr;
		logic write_collision_clr;
	} sw_req_t;
	// Static configuration levels
	typedef struct packed {
		logic enable;
		logic master;
		logic ten_bit;
		logic stretch;
		logic gce;
		logic ack_data;
	} cfg_t;
	typedef enum logic [8:0] {
		M_IDLE    = 9'h001,
		M_RS_LOW  = 9'h002,
		M_ST_WAIT = 9'h004,
		M_ST_HOLD = 9'h008,
		M_BIT_LOW = 9'h010,
		M_BIT_HI  = 9'h020,
		M_SP_LOW  = 9'h040,
		M_SP_HI   = 9'h080,
		M_SP_REL  = 9'h100
	} mst_state_t;
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_ADDR = 4'h2,
		S_RX   = 4'h4,
		S_TX   = 4'h8
	} slv_state_t;
endpackage

//--- verif/i2c_port_assertions.sv
// Concurrent checks on the I2C port top-level ports
`timescale 1ns/100ps
module i2c_port_assertions #(
	parameter int BRG_W = 7
) (
	input wire logic                  mclk_i,
	input wire logic                  rst_i,
	input wire i2c_port_pkg::cfg_t    cfg_i,
	input wire i2c_port_pkg::sw_req_t sw_req_i,
	input wire logic                  scl_oe_o,
	input wire logic                  sda_oe_o,
	input wire logic                  buffer_full_o,
	input wire logic                  scl_release_o,
	input wire logic                  port_irq_flag_o,
	input wire logic                  write_collision_o,
	input wire logic                  ack_status_o,
	input wire logic                  begin_detected_o,
	input wire logic                  end_condition_flag_o,
	input wire logic                  bus_free_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Port off long enough for the pin pipeline to drain
	sequence s_off_long;
		!cfg_i.enable [*8];
	endsequence
	// Stop asked of an enabled master
	sequence s_stop_req;
		sw_req_i.stop && cfg_i.master && cfg_i.enable;
	endsequence
	chk_bus_free_dec: assert property (
		bus_free_o == (end_condition_flag_o || !begin_detected_o))
		else $error("bus free decode wrong");
	chk_disable_clear: assert property (
		!cfg_i.enable |-> ##[1:3] (!begin_detected_o && !end_condition_flag_o))
		else $error("start/stop flags kept while disabled");
	chk_oe_off: assert property (s_off_long |-> !scl_oe_o && !sda_oe_o)
		else $error("pins driven while disabled");
	chk_stop_wait: assert property (s_stop_req |=> !$rose(port_irq_flag_o) [*4])
		else $error("stop flagged too early");
	chk_ack_flag: assert property ($changed(ack_status_o) |-> ##[0:2] port_irq_flag_o)
		else $error("ack stored without flag");
	chk_write_collision_cause: assert property (
		$rose(write_collision_o) |-> $past(sw_req_i.buf_wr) && $past(cfg_i.master))
		else $error("collision without buffer write");
	chk_buf_taken: assert property (
		sw_req_i.buf_wr |=> buffer_full_o || write_collision_o)
		else $error("buffer write neither taken nor refused");
	chk_rel_set: assert property (sw_req_i.rel_set |=> scl_release_o)
		else $error("release set ignored");
endmodule
bind i2c_port i2c_port_assertions #(.BRG_W(BRG_W)) chk_u (.*);

//--- verif/i2c_port_tb.sv
// Bench: master traffic of the I2C port against a slave model
`timescale 1ns/100ps
module i2c_port_tb;
	localparam logic [9:0] BW = 10'h200; // Buffer write
	localparam logic [9:0] AW = 10'h080; // Address/baud write
	localparam logic [9:0] RL = 10'h040; // Release set
	localparam logic [9:0] ST = 10'h020; // Start
	localparam logic [9:0] RS = 10'h010; // Repeated start
	localparam logic [9:0] SP = 10'h008; // Stop
	localparam logic [9:0] RX = 10'h004; // Receive byte
	localparam logic [9:0] IC = 10'h002; // Flag clear
	localparam logic [9:0] WC = 10'h001; // Collision clear
	localparam logic [5:0] MST = 6'h30;  // Enabled master, ack low
	logic                  mclk_i, rst_i, link_clk_i, scl_i, sda_i, ack_en;
	logic                  scl_o, sda_o, scl_oe_o, sda_oe_o, buffer_full_o, rw_o;
	logic                  scl_release_o, addr_update_needed_o, port_irq_flag_o;
	logic                  write_collision_o, ack_status_o, bus_free_o;
	logic                  begin_detected_o, end_condition_flag_o;
	logic [7:0]            buf_wdata_i, addr_wdata_i, buf_rdata_o, sbyte;
	i2c_port_pkg::cfg_t    cfg_i;
	i2c_port_pkg::sw_req_t sw_req_i;
	int                    n_mismatch = 0, num_checks = 0, cyc = 0, hi_run = 0, hi_len = 0;
	i2c_port dut_u (.*);
	i2c_slave_model peer_u (
		.dut_scl_oe_i(scl_oe_o),
		.dut_sda_oe_i(sda_oe_o),
		.ack_en_i    (ack_en),
		.scl_o       (scl_i),
		.sda_o       (sda_i),
		.byte_o      (sbyte)
	);
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	// Link clock kept out of phase with the core clock
	initial begin
		link_clk_i = 1'b0;
		#3.1;
		forever #7.5 link_clk_i = ~link_clk_i;
	end
	// Width of each SCL high phase, and the hang limit
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		hi_run <= scl_i ? hi_run + 1 : 0;
		if (!scl_i && hi_run != 0) hi_len <= hi_run;
		if (cyc == 40000) begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic conclude();
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One-cycle strobe; results sampled once that edge has landed
	task automatic strobe(input logic [9:0] r, input logic [7:0] d, input logic [5:0] c);
		@(posedge mclk_i);
		sw_req_i <= i2c_port_pkg::sw_req_t'(r);
		buf_wdata_i <= d;
		addr_wdata_i <= d;
		cfg_i <= i2c_port_pkg::cfg_t'(c);
		@(posedge mclk_i);
		sw_req_i <= '0;
		#1;
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		while (port_irq_flag_o !== 1'b1 && n < 4000) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		chk(port_irq_flag_o, 8'h01);
		strobe(IC, 8'h00, MST);
	endtask
	// Byte out with the slave acking or not
	task automatic send(input logic [7:0] d, input logic a);
		ack_en = a;
		strobe(BW, d, MST);
		chk(buffer_full_o, 8'h01);
		wait_irq();
		chk(sbyte, d);
		chk(ack_status_o, {7'h00, !a});
		chk(buffer_full_o, 8'h00);
	endtask
	initial begin
		rst_i = 1'b1;
		cfg_i = '0;
		sw_req_i = '0;
		buf_wdata_i = 8'h00;
		addr_wdata_i = 8'h00;
		ack_en = 1'b1;
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk(bus_free_o, 8'h01);
		strobe(AW, 8'h83, MST);
		strobe(ST, 8'h00, MST);
		strobe(BW, 8'h11, MST);
		chk(write_collision_o, 8'h01);
		strobe(WC, 8'h00, MST);
		wait_irq();
		chk(begin_detected_o, 8'h01);
		send(8'ha4, 1'b1);
		send(8'h5b, 1'b0);
		// Reload 3 from the low 7 bits: 8 core cycles plus pin latency
		chk({7'h00, hi_len >= 8 && hi_len <= 20}, 8'h01);
		repeat (40) @(posedge mclk_i);
		#1;
		chk(scl_oe_o, 8'h01);
		strobe(RL, 8'h00, MST);
		chk(scl_release_o, 8'h01);
		chk(addr_update_needed_o, 8'h00);
		strobe(SP, 8'h00, MST);
		chk(port_irq_flag_o, 8'h00);
		wait_irq();
		chk(end_condition_flag_o, 8'h01);
		strobe(ST, 8'h00, MST);
		wait_irq();
		send(8'ha5, 1'b1);
		strobe(RX, 8'h00, MST);
		wait_irq();
		chk(buf_rdata_o, 8'hff);
		strobe(RS, 8'h00, MST);
		wait_irq();
		strobe(SP, 8'h00, MST);
		wait_irq();
		strobe(10'h000, 8'h00, 6'h00);
		repeat (10) @(posedge mclk_i);
		#1;
		chk(begin_detected_o, 8'h00);
		chk(end_condition_flag_o, 8'h00);
		chk(scl_oe_o, 8'h00);
		chk({6'h00, scl_o, sda_o}, 8'h00);
		chk(rw_o, 8'h00);
		chk(bus_free_o, 8'h01);
		conclude();
	end
endmodule

//--- verif/i2c_slave_model.sv
// Slave-side partner: pulled-up wired lines, ack and byte capture
`timescale 1ns/100ps
module i2c_slave_model (
	input  wire logic  dut_scl_oe_i,
	input  wire logic  dut_sda_oe_i,
	input  wire logic  ack_en_i,
	output logic       scl_o,
	output logic       sda_o,
	output logic [7:0] byte_o
);
	logic ack_drv; // Slave pulls SDA for its ack
	int   nbit;    // Pulses since start
	// Pull-ups: a released line reads high
	assign scl_o = !dut_scl_oe_i;
	assign sda_o = !(dut_sda_oe_i || ack_drv);
	initial begin
		ack_drv = 1'b0;
		nbit = 0;
		byte_o = 8'h00;
	end
	// Start condition restarts the count
	always @(negedge sda_o) begin
		if (scl_o) nbit = 0;
	end
	// Bits taken on rising SCL, MSB first
	always @(posedge scl_o) begin
		if (nbit < 8) byte_o = {byte_o[6:0], sda_o};
		nbit = nbit + 1;
	end
	// Ack held through the ninth pulse only
	always @(negedge scl_o) begin
		ack_drv = (nbit == 8) && ack_en_i;
		if (nbit >= 9) nbit = 0;
	end
endmodule
